// file: logic/cis_seq.v
// cpu interrupt sequencer with an axi4-lite register slave
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "cis_seq_consts.vh"
module cis_seq #(
  parameter NUM_LEVELS = 8,
  parameter ADDR_W = 12
) (
  input wire core_clk,
  input wire rst_n,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NUM_LEVELS-1:0] levelReq,
  input wire [NUM_LEVELS-1:0] levelSrcEn,
  input wire [7:0] levelVector,
  input wire instrDone,
  input wire returnExec,
  input wire irqOnExec,
  input wire irqOffExec,
  input wire [15:0] pcIn,
  input wire [7:0] flagsIn,
  input wire [7:0] popData,
  input wire [7:0] vecData,
  output reg [NUM_LEVELS-1:0] levelAck,
  output reg pushStb,
  output reg [7:0] pushData,
  output reg popStb,
  output reg vecStb,
  output reg [7:0] vecAddr,
  output reg pcLoad,
  output reg [15:0] pcOut,
  output reg flagsLoad,
  output reg [7:0] flagsOut,
  output reg globalEn,
  output reg seqBusy
);

  localparam ST_IDLE = 4'h0;
  localparam ST_PUSHL = 4'h1;
  localparam ST_PUSHH = 4'h2;
  localparam ST_PUSHF = 4'h3;
  localparam ST_VECH = 4'h4;
  localparam ST_VECL = 4'h5;
  localparam ST_VECW = 4'h6;
  localparam ST_PAD = 4'h7;
  localparam ST_FWAIT = 4'h8;
  localparam ST_RPOPH = 4'h9;
  localparam ST_RPOPL = 4'hA;
  localparam ST_RDONE = 4'hB;

  function [2:0] regSel;
    input [ADDR_W-1:0] addr;
    begin
      if (addr[1:0] != 2'h0 || addr[ADDR_W-1:10] != 0) begin
        regSel = `CIS_SEL_NONE;
      end else begin
        case (addr[9:2])
          `CIS_IDX_MODE: regSel = `CIS_SEL_MODE;
          `CIS_IDX_MASK: regSel = `CIS_SEL_MASK;
          `CIS_IDX_FPH: regSel = `CIS_SEL_FPH;
          `CIS_IDX_FPL: regSel = `CIS_SEL_FPL;
          `CIS_IDX_REQ: regSel = `CIS_SEL_REQ;
          `CIS_IDX_STAT: regSel = `CIS_SEL_STAT;
          default: regSel = `CIS_SEL_NONE;
        endcase
      end
    end
  endfunction

  reg [4:0] modeQ;
  reg [7:0] maskQ;
  reg [15:0] fastPtrQ;
  reg [7:0] shadowQ;
  reg [3:0] stateQ;
  reg [4:0] cntQ;
  reg [2:0] levelQ;
  reg [15:0] pcSaveQ;
  reg [7:0] flagSaveQ;
  reg [7:0] byteHiQ;
  reg [ADDR_W-1:0] awAddrQ;
  reg awHeldQ;
  reg [31:0] wDataQ;
  reg [3:0] wStrbQ;
  reg wHeldQ;

  wire [NUM_LEVELS-1:0] qualReq = levelReq & levelSrcEn & maskQ[NUM_LEVELS-1:0]
    & {NUM_LEVELS{modeQ[`CIS_MODE_GIE]}};
  reg [2:0] winLevel;
  reg winAny;
  integer i;
  always @* begin
    winLevel = 3'h0;
    winAny = 1'b0;
    for (i = NUM_LEVELS - 1; i >= 0; i = i - 1) begin
      if (qualReq[i]) begin
        winLevel = i[2:0];
        winAny = 1'b1;
      end
    end
  end

  wire fastHit = modeQ[`CIS_MODE_FEN] &&
    (winLevel == modeQ[`CIS_MODE_FSEL_HI:`CIS_MODE_FSEL_LO]);

  wire doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;
  wire [2:0] wSel = regSel(awAddrQ);
  wire [2:0] rSel = regSel(s_axi_araddr);
  wire idle = (stateQ == ST_IDLE);
  wire takeIrq = idle && instrDone && winAny && !returnExec;
  // fast bit picks the return path
  wire fastRet = idle && returnExec && flagsIn[`CIS_FLAG_FAST];
  wire normRet = idle && returnExec && !flagsIn[`CIS_FLAG_FAST];

  // axi write channel: address and data held independently
  always @(posedge core_clk) begin
    if (!rst_n) begin
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      awAddrQ <= {ADDR_W{1'b0}};
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CIS_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeldQ && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeldQ && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldQ <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldQ <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeldQ <= 1'b0;
        wHeldQ <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wSel == `CIS_SEL_NONE || wSel == `CIS_SEL_REQ ||
          wSel == `CIS_SEL_STAT) ? `CIS_RESP_SLVERR : `CIS_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel: one read outstanding, answer the cycle after taking
  always @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CIS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CIS_RESP_OKAY;
        case (rSel)
          `CIS_SEL_MODE: s_axi_rdata <= {27'h0000000, modeQ};
          `CIS_SEL_MASK: s_axi_rdata <= {24'h000000, maskQ};
          `CIS_SEL_FPH: s_axi_rdata <= {24'h000000, fastPtrQ[15:8]};
          `CIS_SEL_FPL: s_axi_rdata <= {24'h000000, fastPtrQ[7:0]};
          `CIS_SEL_REQ: s_axi_rdata <= {{(32-NUM_LEVELS){1'b0}}, levelReq};
          `CIS_SEL_STAT: s_axi_rdata <= {24'h000000, shadowQ[0], levelQ,
            stateQ};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CIS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // mode, mask and fast pointer; hardware updates win over software
  always @(posedge core_clk) begin
    if (!rst_n) begin
      modeQ <= `CIS_MODE_RST;
      maskQ <= `CIS_MASK_RST;
      fastPtrQ <= `CIS_FP_RST;
    end else begin
      if (doWrite && wStrbQ[0]) begin
        case (wSel)
          `CIS_SEL_MODE: modeQ <= wDataQ[4:0];
          `CIS_SEL_MASK: maskQ <= wDataQ[7:0];
          // high byte at first index, low at next
          `CIS_SEL_FPH: fastPtrQ[15:8] <= wDataQ[7:0];
          `CIS_SEL_FPL: fastPtrQ[7:0] <= wDataQ[7:0];
          default: modeQ <= modeQ;
        endcase
      end
      if (irqOnExec) begin
        modeQ[`CIS_MODE_GIE] <= 1'b1;
      end else if (irqOffExec) begin
        modeQ[`CIS_MODE_GIE] <= 1'b0;
      end
      if (takeIrq) begin
        modeQ[`CIS_MODE_GIE] <= 1'b0;
      end
      if (fastRet || stateQ == ST_RDONE) begin
        modeQ[`CIS_MODE_GIE] <= 1'b1;
      end
      // swap pointer and pc on entry
      if (stateQ == ST_FWAIT && cntQ == `CIS_FAST_CYC) begin
        fastPtrQ <= pcSaveQ;
      end
      if (fastRet) begin
        fastPtrQ <= pcIn;
      end
    end
  end

  // entry and return sequencer
  always @(posedge core_clk) begin
    if (!rst_n) begin
      stateQ <= ST_IDLE;
      cntQ <= 5'h00;
      levelQ <= 3'h0;
      pcSaveQ <= 16'h0000;
      flagSaveQ <= 8'h00;
      byteHiQ <= 8'h00;
      shadowQ <= 8'h00;
      levelAck <= {NUM_LEVELS{1'b0}};
      pushStb <= 1'b0;
      pushData <= 8'h00;
      popStb <= 1'b0;
      vecStb <= 1'b0;
      vecAddr <= 8'h00;
      pcLoad <= 1'b0;
      pcOut <= 16'h0000;
      flagsLoad <= 1'b0;
      flagsOut <= 8'h00;
      globalEn <= 1'b0;
      seqBusy <= 1'b0;
    end else begin
      levelAck <= {NUM_LEVELS{1'b0}};
      pushStb <= 1'b0;
      popStb <= 1'b0;
      vecStb <= 1'b0;
      pcLoad <= 1'b0;
      flagsLoad <= 1'b0;
      globalEn <= modeQ[`CIS_MODE_GIE];
      seqBusy <= !idle || takeIrq || normRet;
      if (!idle) begin
        cntQ <= cntQ + 5'h01;
      end
      case (stateQ)
        ST_IDLE: begin
          // nesting needs only a re-enabled global bit
          if (takeIrq) begin
            // pending clear left to the source side
            levelAck <= {{(NUM_LEVELS-1){1'b0}}, 1'b1} << winLevel;
            levelQ <= winLevel;
            pcSaveQ <= pcIn;
            flagSaveQ <= flagsIn;
            cntQ <= 5'h01;
            stateQ <= fastHit ? ST_FWAIT : ST_PUSHL;
          end else if (fastRet) begin
            pcOut <= fastPtrQ;
            pcLoad <= 1'b1;
            flagsOut <= shadowQ & ~(8'h01 << `CIS_FLAG_FAST);
            flagsLoad <= 1'b1;
          end else if (normRet) begin
            popStb <= 1'b1;
            stateQ <= ST_RPOPH;
          end
        end
        ST_PUSHL: begin
          pushStb <= 1'b1;
          pushData <= pcSaveQ[7:0];
          stateQ <= ST_PUSHH;
        end
        ST_PUSHH: begin
          pushStb <= 1'b1;
          pushData <= pcSaveQ[15:8];
          stateQ <= ST_PUSHF;
        end
        ST_PUSHF: begin
          pushStb <= 1'b1;
          pushData <= flagSaveQ;
          stateQ <= ST_VECH;
        end
        // start at the even slot address
        ST_VECH: begin
          vecStb <= 1'b1;
          vecAddr <= {levelVector[7:1], 1'b0};
          stateQ <= ST_VECL;
        end
        ST_VECL: begin
          vecStb <= 1'b1;
          vecAddr <= {vecAddr[7:1], 1'b1};
          byteHiQ <= vecData;
          stateQ <= ST_VECW;
        end
        ST_VECW: begin
          pcOut <= {byteHiQ, vecData};
          stateQ <= ST_PAD;
        end
        // normal entry completes on cycle 16
        ST_PAD: begin
          if (cntQ == `CIS_NORMAL_CYC) begin
            pcLoad <= 1'b1;
            stateQ <= ST_IDLE;
          end
        end
        // fast entry completes on cycle 6
        ST_FWAIT: begin
          if (cntQ == `CIS_FAST_CYC) begin
            pcOut <= fastPtrQ;
            pcLoad <= 1'b1;
            shadowQ <= flagSaveQ;
            flagsOut <= flagSaveQ | (8'h01 << `CIS_FLAG_FAST);
            flagsLoad <= 1'b1;
            stateQ <= ST_IDLE;
          end
        end
        ST_RPOPH: begin
          popStb <= 1'b1;
          flagsOut <= popData;
          stateQ <= ST_RPOPL;
        end
        ST_RPOPL: begin
          popStb <= 1'b1;
          byteHiQ <= popData;
          stateQ <= ST_RDONE;
        end
        ST_RDONE: begin
          pcOut <= {byteHiQ, popData};
          pcLoad <= 1'b1;
          flagsLoad <= 1'b1;
          stateQ <= ST_IDLE;
        end
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

endmodule // cis_seq

// file: logic/cis_seq_consts.vh
// register offsets, field positions, reset values and cycle counts
`ifndef CIS_SEQ_CONSTS_VH
`define CIS_SEQ_CONSTS_VH
// register indices; byte address is four times the index
`define CIS_IDX_REQ 8'hDC
`define CIS_IDX_MASK 8'hDD
`define CIS_IDX_MODE 8'hDE
`define CIS_IDX_STAT 8'hDF
`define CIS_IDX_FPH 8'hDA
`define CIS_IDX_FPL 8'hDB
// mode register fields
`define CIS_MODE_GIE 0
`define CIS_MODE_FEN 1
`define CIS_MODE_FSEL_LO 2
`define CIS_MODE_FSEL_HI 4
`define CIS_MODE_RST 5'h00
`define CIS_MASK_RST 8'h00
`define CIS_FP_RST 16'h0000
// fast status bit inside the cpu flag byte
`define CIS_FLAG_FAST 1
// entry lengths in core_clk cycles, counted from the acknowledge
`define CIS_NORMAL_CYC 5'h10
`define CIS_FAST_CYC 5'h06
// register select codes
`define CIS_SEL_NONE 3'h0
`define CIS_SEL_MODE 3'h1
`define CIS_SEL_MASK 3'h2
`define CIS_SEL_FPH 3'h3
`define CIS_SEL_FPL 3'h4
`define CIS_SEL_REQ 3'h5
`define CIS_SEL_STAT 3'h6
`define CIS_RESP_OKAY 2'h0
`define CIS_RESP_SLVERR 2'h2
`endif

// file: verification/cis_seq_chk.sv
// concurrent checks on the interrupt sequencer ports
`timescale 1ns/10ps
module cis_seq_chk #(
  parameter NUM_LEVELS = 8
) (
  input wire core_clk,
  input wire rst_n,
  input wire [NUM_LEVELS-1:0] levelReq,
  input wire [NUM_LEVELS-1:0] levelSrcEn,
  input wire instrDone,
  input wire returnExec,
  input wire [7:0] flagsIn,
  input wire [NUM_LEVELS-1:0] levelAck,
  input wire pushStb,
  input wire popStb,
  input wire vecStb,
  input wire [7:0] vecAddr,
  input wire pcLoad,
  input wire flagsLoad,
  input wire [7:0] flagsOut,
  input wire globalEn,
  input wire seqBusy
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence vecPair;
    (vecStb && !vecAddr[0]) ##1 (vecStb && vecAddr[0]);
  endsequence
  sequence popRun;
    popStb [*3] ##1 (pcLoad && flagsLoad);
  endsequence
  chk_ack_boundary:
  assert property (|levelAck |-> $past(instrDone) && !$past(returnExec))
    else $error("ack away from instruction end");
  chk_ack_qualified:
  assert property (|levelAck |-> $onehot(levelAck) &&
    |($past(levelReq) & $past(levelSrcEn) & levelAck))
    else $error("ack for an unqualified level");
  chk_ack_idle:
  // busy still shows on the load edge, so a take right after it is legal
  assert property (|levelAck |-> !$past(seqBusy) || $past(pcLoad))
    else $error("ack while busy");
  chk_gie_drop:
  assert property (|levelAck |-> ##[0:1] !globalEn)
    else $error("global enable kept on entry");
  chk_push_order:
  assert property ($rose(pushStb) |-> pushStb [*3] ##1 vecPair)
    else $error("push or vector order wrong");
  chk_vec_branch:
  assert property ($rose(vecStb) |-> vecPair ##11 pcLoad)
    else $error("normal entry length wrong");
  chk_fast_entry:
  assert property (|levelAck ##1 !pushStb |->
    ##5 (pcLoad && flagsLoad && flagsOut[1]))
    else $error("fast entry wrong");
  chk_fast_return:
  assert property (returnExec && !seqBusy && flagsIn[1] |=>
    (pcLoad && flagsLoad && !flagsOut[1]) ##[1:2] globalEn)
    else $error("fast return wrong");
  chk_normal_return:
  assert property (returnExec && !seqBusy && !flagsIn[1] |=>
    popRun ##[0:2] globalEn)
    else $error("normal return wrong");
endmodule // cis_seq_chk

bind cis_seq cis_seq_chk #(.NUM_LEVELS(NUM_LEVELS)) chk (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .levelReq(levelReq),
  .levelSrcEn(levelSrcEn),
  .instrDone(instrDone),
  .returnExec(returnExec),
  .flagsIn(flagsIn),
  .levelAck(levelAck),
  .pushStb(pushStb),
  .popStb(popStb),
  .vecStb(vecStb),
  .vecAddr(vecAddr),
  .pcLoad(pcLoad),
  .flagsLoad(flagsLoad),
  .flagsOut(flagsOut),
  .globalEn(globalEn),
  .seqBusy(seqBusy)
);

// file: verification/cis_src_model.sv
// peripheral sources holding level requests until acknowledged
`timescale 1ns/10ps
module cis_src_model (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] raise,
  input wire [7:0] levelAck,
  output reg [7:0] levelReq,
  output reg [7:0] levelVector
);
  integer i;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      levelReq <= 8'h00;
      levelVector <= 8'h00;
    end else begin
      levelReq <= (levelReq | raise) & ~levelAck;
      for (i = 0; i < 8; i = i + 1) begin
        if (levelAck[i]) levelVector <= {i[6:0], 1'h0};
      end
    end
  end
endmodule // cis_src_model

// file: verification/tb_top.sv
// self-checking bench for the interrupt sequencer
`timescale 1ns/10ps
`include "cis_seq_consts.vh"
module tb_top;
  localparam logic [11:0] aMode = {2'h0, `CIS_IDX_MODE, 2'h0};
  localparam logic [11:0] aMask = {2'h0, `CIS_IDX_MASK, 2'h0};
  localparam logic [11:0] aFph = {2'h0, `CIS_IDX_FPH, 2'h0};
  localparam logic [11:0] aFpl = {2'h0, `CIS_IDX_FPL, 2'h0};
  localparam logic [11:0] aReq = {2'h0, `CIS_IDX_REQ, 2'h0};
  logic core_clk = 0;
  logic rst_n = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [7:0] raise = 0, levelSrcEn = 8'hFF, flagsIn = 8'h81;
  logic [7:0] popData = 8'h01;
  logic instrDone = 1, returnExec = 0, irqOnExec = 0, irqOffExec = 0;
  logic [15:0] pcIn = 16'h4321;
  wire [7:0] levelReq, levelVector, levelAck, pushData, vecAddr, flagsOut;
  // program memory answers within the strobe cycle, as the sequencer reads it
  wire [7:0] vecData = vecAddr[0] ? 8'h34 : 8'h12;
  wire pushStb, popStb, vecStb, pcLoad, flagsLoad, globalEn, seqBusy;
  wire [15:0] pcOut;
  logic [7:0] ackSeen = 8'h00;
  logic [7:0] pushQ[$], vecQ[$];
  logic [1:0] rsp;
  logic [31:0] rd;
  int fail_count = 0, samples_checked = 0;

  cis_seq uut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .levelReq(levelReq),
    .levelSrcEn(levelSrcEn),
    .levelVector(levelVector),
    .instrDone(instrDone),
    .returnExec(returnExec),
    .irqOnExec(irqOnExec),
    .irqOffExec(irqOffExec),
    .pcIn(pcIn),
    .flagsIn(flagsIn),
    .popData(popData),
    .vecData(vecData),
    .levelAck(levelAck),
    .pushStb(pushStb),
    .pushData(pushData),
    .popStb(popStb),
    .vecStb(vecStb),
    .vecAddr(vecAddr),
    .pcLoad(pcLoad),
    .pcOut(pcOut),
    .flagsLoad(flagsLoad),
    .flagsOut(flagsOut),
    .globalEn(globalEn),
    .seqBusy(seqBusy)
  );
  cis_src_model src (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .raise(raise),
    .levelAck(levelAck),
    .levelReq(levelReq),
    .levelVector(levelVector)
  );

  initial forever #25 core_clk = ~core_clk;

  // stack shows its next byte in the strobe cycle, steps on each pop
  always @(posedge core_clk) begin
    if (pushStb) pushQ.push_back(pushData);
    if (vecStb) vecQ.push_back(vecAddr);
    if (|levelAck) ackSeen <= levelAck;
    if (popStb) popData <= popData + 8'h01;
  end

  task chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one transfer; hs flags sampled at negedge equal the next edge's view
  task axi(input logic wr, input logic [11:0] a, input logic [7:0] d);
    logic aw, w, ar, done;
    // callers may return on a falling edge; start right after a rising one
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    for (int n = 0; n < 40; n++) begin
      @(negedge core_clk);
      aw = s_axi_awready;
      w = s_axi_wready;
      ar = s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (ar) s_axi_arvalid <= 1'h0;
      if (done) return;
    end
    chk("bus timeout", 0, 1);
    give_verdict;
  endtask

  task waitLoad;
    for (int n = 0; n < 60; n++) begin
      @(negedge core_clk);
      if (pcLoad) return;
    end
    chk("load timeout", 0, 1);
    give_verdict;
  endtask

  task raiseReq(input logic [7:0] m);
    @(posedge core_clk);
    raise <= m;
    @(posedge core_clk);
    raise <= 8'h00;
  endtask

  task doRet;
    @(posedge core_clk);
    returnExec <= 1'h1;
    @(posedge core_clk);
    returnExec <= 1'h0;
    waitLoad;
  endtask

  task swGie(input logic on);
    @(posedge core_clk);
    irqOnExec <= on;
    irqOffExec <= !on;
    @(posedge core_clk);
    irqOnExec <= 1'h0;
    irqOffExec <= 1'h0;
    repeat (8) @(posedge core_clk);
  endtask

  task tRegs;
    axi(0, aMode, 8'h00);
    chk("mode reset", rd, 0);
    axi(0, aMask, 8'h00);
    chk("mask reset", rd, 0);
    axi(0, 12'hFF0, 8'h00);
    chk("unmapped", rsp, `CIS_RESP_SLVERR);
    axi(1, aReq, 8'hFF);
    chk("ro write", rsp, `CIS_RESP_SLVERR);
    $display("test regs done");
  endtask

  task tNormal;
    axi(1, aMask, 8'hFF);
    axi(1, aMode, 8'h01);
    instrDone <= 1'h0;
    raiseReq(8'h04);
    repeat (6) @(posedge core_clk);
    chk("early ack", ackSeen, 0);
    instrDone <= 1'h1;
    waitLoad;
    chk("branch", pcOut, 16'h1234);
    chk("pushes", {pushQ[0], pushQ[1], pushQ[2]}, 24'h214381);
    chk("vector", {vecQ[0], vecQ[1]}, 16'h0405);
    chk("ack", ackSeen, 8'h04);
    chk("gie off", globalEn, 0);
    doRet;
    chk("restore", {pcOut, flagsOut}, 24'h020301);
    repeat (3) @(posedge core_clk);
    chk("gie on", globalEn, 1);
    $display("test normal done");
  endtask

  task tPrio;
    axi(1, aMask, 8'hF7);
    raiseReq(8'h28);
    waitLoad;
    chk("masked lose", ackSeen, 8'h20);
    axi(0, aReq, 8'h00);
    chk("poll pending", rd, 8'h08);
    doRet;
    swGie(0);
    axi(1, aMask, 8'hFF);
    repeat (8) @(posedge core_clk);
    chk("gie gate", ackSeen, 8'h20);
    levelSrcEn <= 8'hF7;
    swGie(1);
    chk("src gate", ackSeen, 8'h20);
    levelSrcEn <= 8'hFF;
    waitLoad;
    chk("next level", ackSeen, 8'h08);
    doRet;
    // two levels at once: lower number first, the other right after return
    raiseReq(8'h30);
    waitLoad;
    chk("top first", ackSeen, 8'h10);
    doRet;
    waitLoad;
    chk("then next", ackSeen, 8'h20);
    doRet;
    $display("test priority done");
  endtask

  task tFast;
    axi(1, aFph, 8'hAB);
    axi(1, aFpl, 8'hCD);
    for (int lv = 0; lv < 8; lv++) begin
      pushQ.delete();
      axi(1, aMode, {3'h0, lv[2:0], 2'h3});
      raiseReq(8'h01 << lv);
      waitLoad;
      chk("fast entry", {pcOut, flagsOut}, 24'hABCD83);
      chk("fast stack", pushQ.size(), 0);
      @(posedge core_clk);
      pcIn <= 16'hABCD;
      flagsIn <= 8'h83;
      doRet;
      chk("fast return", {pcOut, flagsOut}, 24'h432181);
      @(posedge core_clk);
      pcIn <= 16'h4321;
      flagsIn <= 8'h81;
    end
    axi(0, aFph, 8'h00);
    chk("ptr high", rd, 8'hAB);
    axi(0, aFpl, 8'h00);
    chk("ptr low", rd, 8'hCD);
    $display("test fast done");
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    tRegs;
    tNormal;
    tPrio;
    tFast;
    give_verdict;
  end
endmodule // tb_top
